// *** rtl/ocr_seq.sv ***
// Over-current fault response decoder and shutdown/retry sequencer
//
// Contract
// - Mode 11 disables while fault, auto-resumes.
// - Retry 000 means no restart, latch off.
// - Retry 001 gives exactly one attempt.
// - Retry 010..110 give two to six attempts.
// - Attempts used up: output off until cleared.
// - Attempt starts spaced by delay times unit.
// - Retry 111 retries without any limit.
// - Off by pin or command stops retrying.
// - Another shutdown fault stops retrying.
// - Delay field n selects 2^n units.
// - Delay is hold time or retry spacing.
// - Unit length comes from separate register.
// - Every mode sets the over-current status bit.
// - Mode 10 holds limit, then applies retry.
`timescale 1ns/1ps
`default_nettype none

`include "ocr_regs.svh"

module ocr_seq (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_link_i,
    input wire logic rst_link_n_i,
    input wire logic resp_wr_i,
    input wire logic [7:0] resp_wdata_i,
    output logic [7:0] resp_rdata_o,
    output logic status_link_o,
    input wire ocr_pkg::ocr_pins_t pins_i,
    input wire logic op_cmd_on_i,
    input wire logic fault_clear_i,
    input wire logic [15:0] unit_cycles_i,
    output logic out_en_o,
    output logic oc_status_o,
    output logic alert_o,
    output logic retrying_o,
    output logic cur_hold_o,
    output logic [2:0] attempts_o
);
    import ocr_pkg::*;

    // Link domain: the response byte lives here, next to the host's write port
    ocr_link_t lk;
    ocr_link_t next_lk;
    logic status_at_link;

    always_comb begin
        next_lk = lk;
        next_lk.status = status_at_link;
        if (resp_wr_i) begin
            next_lk.resp = resp_wdata_i;
            next_lk.tog = ~lk.tog;
        end
    end

    always_ff @(posedge clk_link_i or negedge rst_link_n_i) begin
        if (!rst_link_n_i) begin
            lk.resp <= `OCR_RESP_RST;
            lk.tog <= 1'b0;
            lk.status <= 1'b0;
        end else begin
            lk <= next_lk;
        end
    end

    assign resp_rdata_o = lk.resp;
    assign status_link_o = lk.status;

    // Core domain
    ocr_core_t st;
    ocr_core_t next_st;
    ocr_pins_t pins_s;
    logic tog_s;

    // Pins are independent levels, so each bit may settle on its own edge
    ocr_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pins_i),
        .sync_o(pins_s)
    );

    // Toggle crossing; the byte is stable long before the toggle arrives
    ocr_sync #(
        .WIDTH(1)
    ) u_tog_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(lk.tog),
        .sync_o(tog_s)
    );

    // Status is a slow level, so two flops suffice; the link copy lags a few link cycles
    ocr_sync #(
        .WIDTH(1)
    ) u_stat_sync (
        .clk_i(clk_link_i),
        .rst_n_i(rst_link_n_i),
        .async_i(st.status),
        .sync_o(status_at_link)
    );

    logic [15:0] unit_last;
    logic [7:0] units_last;
    logic tmr_done;
    logic tmr_start;
    logic tmr_stop;
    logic on_cmd;
    logic try_failed;
    logic tries_left;
    ocr_resp_t resp_new;

    always_comb begin
        resp_new.mode = lk.resp[`OCR_MODE_MSB:`OCR_MODE_LSB];
        resp_new.retry = lk.resp[`OCR_RETRY_MSB:`OCR_RETRY_LSB];
        resp_new.dly = lk.resp[`OCR_DLY_MSB:`OCR_DLY_LSB];
    end

    always_comb begin
        // A zero unit length is taken as one cycle so the timer always ends
        if (unit_cycles_i == `OCR_CNT_ZERO) begin
            unit_last = `OCR_CNT_ZERO;
        end else begin
            unit_last = unit_cycles_i - `OCR_CNT_ONE;
        end
        units_last = (`OCR_UNITS_ONE << st.resp.dly) - `OCR_NUM_ONE;
        // Done on the last cycle of the last unit, one edge before the interval ends
        tmr_done = st.tmr_run && (st.unit_cnt == unit_last)
            && (st.unit_num == units_last);
    end

    always_comb begin
        // The command comes from core-domain logic and needs no synchroniser
        on_cmd = pins_s.pin_on && op_cmd_on_i;
        // In mode 01 a restart fails on the low-voltage condition only
        if (st.resp.mode == `OCR_MODE_COND) begin
            try_failed = pins_s.lv_fault;
        end else begin
            try_failed = pins_s.oc_fault;
        end
        // Attempts counts started attempts, so the last one is judged on its failure
        tries_left = (st.resp.retry == `OCR_RETRY_CONT)
            || (st.attempts < st.resp.retry);
    end

    // OFF: output disabled by pin, command or a foreign fault
    // RUN: normal operation, watching the synchronised fault pins
    // HOLD: current-limit window of the delayed mode
    // WAIT: output off, timer runs toward the next attempt start
    // TRY: output on for one attempt, a failure drops it at once
    // LATCH: output off until the host clears the fault
    // PAUSE: output off while the fault lasts, then resumes
    always_comb begin
        next_st = st;
        tmr_start = 1'b0;
        tmr_stop = 1'b0;
        // A changed toggle means a new byte that has been stable for two core cycles
        next_st.tog_seen = tog_s;
        if (tog_s != st.tog_seen) begin
            next_st.resp = resp_new;
        end

        // Set wins over clear on the sticky status bit
        if (pins_s.oc_fault && st.out_en) begin
            next_st.status = 1'b1;
        end else if (fault_clear_i) begin
            next_st.status = 1'b0;
        end

        // Off and foreign faults outrank every state, so no retry outlives them
        if (!on_cmd || pins_s.other_fault) begin
            next_st.state = OCR_ST_OFF;
            next_st.out_en = 1'b0;
            next_st.attempts = `OCR_TRY_ZERO;
            tmr_stop = 1'b1;
        end else begin
            case (st.state)
                OCR_ST_OFF: begin
                    next_st.state = OCR_ST_RUN;
                    next_st.out_en = 1'b1;
                end
                OCR_ST_RUN: begin
                    if (pins_s.oc_fault) begin
                        case (st.resp.mode)
                            `OCR_MODE_IGNORE: begin
                                next_st.state = OCR_ST_RUN;
                            end
                            `OCR_MODE_COND: begin
                                if (pins_s.lv_fault) begin
                                    next_st.out_en = 1'b0;
                                    if (st.resp.retry == `OCR_RETRY_NONE) begin
                                        next_st.state = OCR_ST_LATCH;
                                    end else begin
                                        next_st.state = OCR_ST_WAIT;
                                        tmr_start = 1'b1;
                                    end
                                end
                            end
                            `OCR_MODE_DELAY: begin
                                next_st.state = OCR_ST_HOLD;
                                tmr_start = 1'b1;
                            end
                            `OCR_MODE_RESUME: begin
                                next_st.state = OCR_ST_PAUSE;
                                next_st.out_en = 1'b0;
                            end
                            default: begin
                                next_st.state = OCR_ST_RUN;
                            end
                        endcase
                    end
                end
                OCR_ST_HOLD: begin
                    if (!pins_s.cur_limit) begin
                        next_st.state = OCR_ST_RUN;
                        tmr_stop = 1'b1;
                    end else if (tmr_done) begin
                        next_st.out_en = 1'b0;
                        if (st.resp.retry == `OCR_RETRY_NONE) begin
                            next_st.state = OCR_ST_LATCH;
                        end else begin
                            next_st.state = OCR_ST_WAIT;
                            tmr_start = 1'b1;
                        end
                    end
                end
                OCR_ST_WAIT: begin
                    // The same timer runs from one attempt start to the next
                    if (fault_clear_i) begin
                        next_st.state = OCR_ST_RUN;
                        next_st.out_en = 1'b1;
                        next_st.attempts = `OCR_TRY_ZERO;
                        tmr_stop = 1'b1;
                    end else if (tmr_done || !st.tmr_run) begin
                        next_st.state = OCR_ST_TRY;
                        next_st.out_en = 1'b1;
                        tmr_start = 1'b1;
                        if (st.resp.retry != `OCR_RETRY_CONT) begin
                            next_st.attempts = st.attempts + `OCR_TRY_ONE;
                        end
                    end
                end
                OCR_ST_TRY: begin
                    if (fault_clear_i) begin
                        next_st.state = OCR_ST_RUN;
                        next_st.attempts = `OCR_TRY_ZERO;
                        tmr_stop = 1'b1;
                    end else if (try_failed) begin
                        next_st.out_en = 1'b0;
                        if (tries_left) begin
                            next_st.state = OCR_ST_WAIT;
                        end else begin
                            next_st.state = OCR_ST_LATCH;
                            tmr_stop = 1'b1;
                        end
                    end else if (tmr_done) begin
                        next_st.state = OCR_ST_RUN;
                        next_st.attempts = `OCR_TRY_ZERO;
                    end
                end
                OCR_ST_LATCH: begin
                    // Only the host's clear, an off/on cycle or a foreign fault leaves this state
                    next_st.out_en = 1'b0;
                    if (fault_clear_i) begin
                        next_st.state = OCR_ST_RUN;
                        next_st.out_en = 1'b1;
                        next_st.attempts = `OCR_TRY_ZERO;
                    end
                end
                OCR_ST_PAUSE: begin
                    if (!pins_s.oc_fault) begin
                        next_st.state = OCR_ST_RUN;
                        next_st.out_en = 1'b1;
                    end
                end
                default: begin
                    next_st.state = OCR_ST_OFF;
                    next_st.out_en = 1'b0;
                end
            endcase
        end

        // Units of cycles keep two short counters instead of one wide product
        if (tmr_start) begin
            next_st.tmr_run = 1'b1;
            next_st.unit_cnt = `OCR_CNT_ZERO;
            next_st.unit_num = `OCR_NUM_ZERO;
        end else if (tmr_stop) begin
            next_st.tmr_run = 1'b0;
        end else if (st.tmr_run) begin
            if (st.unit_cnt == unit_last) begin
                next_st.unit_cnt = `OCR_CNT_ZERO;
                if (st.unit_num == units_last) begin
                    next_st.tmr_run = 1'b0;
                end else begin
                    next_st.unit_num = st.unit_num + `OCR_NUM_ONE;
                end
            end else begin
                next_st.unit_cnt = st.unit_cnt + `OCR_CNT_ONE;
            end
        end

        // Flags follow the next state so they change on the same edge as the enable
        next_st.retrying = (next_st.state == OCR_ST_WAIT)
            || (next_st.state == OCR_ST_TRY);
        next_st.cur_hold = (next_st.state == OCR_ST_HOLD);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st.state <= OCR_ST_OFF;
            st.resp <= `OCR_RESP_RST;
            st.tog_seen <= 1'b0;
            st.unit_cnt <= `OCR_CNT_ZERO;
            st.unit_num <= `OCR_NUM_ZERO;
            st.tmr_run <= 1'b0;
            st.attempts <= `OCR_TRY_ZERO;
            st.out_en <= 1'b0;
            st.status <= 1'b0;
            st.retrying <= 1'b0;
            st.cur_hold <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign out_en_o = st.out_en;
    assign oc_status_o = st.status;
    // Host notification follows the sticky status bit
    assign alert_o = st.status;
    assign retrying_o = st.retrying;
    assign cur_hold_o = st.cur_hold;
    assign attempts_o = st.attempts;

endmodule // ocr_seq

`default_nettype wire

// *** rtl/ocr_sync.sv ***
// Two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none

module ocr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ocr_sync_st_t;

    ocr_sync_st_t st;
    ocr_sync_st_t next_st;

    always_comb begin
        next_st.meta = async_i;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.stable;

endmodule // ocr_sync

`default_nettype wire

// *** shared/ocr_pkg.sv ***
// Types shared by the over-current fault retry sequencer
package ocr_pkg;

    typedef enum logic [2:0] {
        OCR_ST_OFF,
        OCR_ST_RUN,
        OCR_ST_HOLD,
        OCR_ST_WAIT,
        OCR_ST_TRY,
        OCR_ST_LATCH,
        OCR_ST_PAUSE
    } ocr_state_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] retry;
        logic [2:0] dly;
    } ocr_resp_t;

    typedef struct packed {
        logic oc_fault;
        logic lv_fault;
        logic cur_limit;
        logic other_fault;
        logic pin_on;
    } ocr_pins_t;

    typedef struct packed {
        ocr_state_t state;
        ocr_resp_t resp;
        logic tog_seen;
        logic [15:0] unit_cnt;
        logic [7:0] unit_num;
        logic tmr_run;
        logic [2:0] attempts;
        logic out_en;
        logic status;
        logic retrying;
        logic cur_hold;
    } ocr_core_t;

    typedef struct packed {
        logic [7:0] resp;
        logic tog;
        logic status;
    } ocr_link_t;

endpackage

// *** shared/ocr_regs.svh ***
// Field positions, encodings and reset values of the over-current response byte
`ifndef OCR_REGS_SVH
`define OCR_REGS_SVH

`define OCR_MODE_MSB 7
`define OCR_MODE_LSB 6
`define OCR_RETRY_MSB 5
`define OCR_RETRY_LSB 3
`define OCR_DLY_MSB 2
`define OCR_DLY_LSB 0

`define OCR_MODE_IGNORE 2'h0
`define OCR_MODE_COND 2'h1
`define OCR_MODE_DELAY 2'h2
`define OCR_MODE_RESUME 2'h3

`define OCR_RETRY_NONE 3'h0
`define OCR_RETRY_CONT 3'h7

`define OCR_RESP_RST 8'h00
`define OCR_UNITS_ONE 8'h01
`define OCR_CNT_ZERO 16'h0000
`define OCR_CNT_ONE 16'h0001
`define OCR_NUM_ZERO 8'h00
`define OCR_NUM_ONE 8'h01
`define OCR_TRY_ZERO 3'h0
`define OCR_TRY_ONE 3'h1

`endif

// *** tb/ocr_host_model.sv ***
// Host model that writes the response byte in the link clock domain
`timescale 1ns/1ps
`default_nettype none

module ocr_host_model (
    input wire logic clk_link_i,
    output logic wr_o,
    output logic [7:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    // Long quiet time after the strobe so the core has taken the byte
    task automatic put(input logic [7:0] b);
        @(negedge clk_link_i);
        wr_o = 1'b1;
        wdata_o = b;
        @(negedge clk_link_i);
        wr_o = 1'b0;
        wdata_o = ~b;
        repeat (8) @(negedge clk_link_i);
    endtask
endmodule // ocr_host_model

`default_nettype wire

// *** tb/ocr_seq_assertions.sv ***
// Concurrent checks on the ports of the fault retry sequencer
`timescale 1ns/1ps
`default_nettype none

module ocr_seq_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_link_i,
    input wire logic rst_link_n_i,
    input wire logic resp_wr_i,
    input wire logic [7:0] resp_wdata_i,
    input wire logic [7:0] resp_rdata_o,
    input wire logic status_link_o,
    input wire ocr_pkg::ocr_pins_t pins_i,
    input wire logic op_cmd_on_i,
    input wire logic fault_clear_i,
    input wire logic [15:0] unit_cycles_i,
    input wire logic out_en_o,
    input wire logic oc_status_o,
    input wire logic alert_o,
    input wire logic retrying_o,
    input wire logic cur_hold_o,
    input wire logic [2:0] attempts_o
);
    import ocr_pkg::*;

    a_alert_mirror: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        alert_o == oc_status_o) else $error("alert differs from status");
    a_status_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        oc_status_o && !fault_clear_i |=> oc_status_o) else $error("status lost");
    a_cmd_off_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !op_cmd_on_i [*2] |-> !out_en_o) else $error("output on while off");
    a_rise_needs_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(out_en_o) |-> $past(op_cmd_on_i)) else $error("enable without command");
    a_other_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pins_i.other_fault [*4] |-> !out_en_o && !retrying_o) else $error("retry on other");
    a_off_clears_try: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !op_cmd_on_i [*2] |-> attempts_o == 3'h0) else $error("attempts kept while off");
    a_hold_keeps_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cur_hold_o |-> out_en_o) else $error("hold with output off");
    a_try_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        attempts_o != 3'h7) else $error("attempt count too high");
    a_wr_readback: assert property (@(posedge clk_link_i) disable iff (!rst_link_n_i)
        resp_wr_i |=> resp_rdata_o == $past(resp_wdata_i)) else $error("byte not kept");
    a_link_status: assert property (@(posedge clk_link_i) disable iff (!rst_link_n_i)
        oc_status_o [*4] |-> status_link_o) else $error("status not crossed");
endmodule // ocr_seq_checker

bind ocr_seq ocr_seq_checker ocr_seq_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .clk_link_i(clk_link_i), .rst_link_n_i(rst_link_n_i), .resp_wr_i(resp_wr_i),
    .resp_wdata_i(resp_wdata_i), .resp_rdata_o(resp_rdata_o), .status_link_o(status_link_o),
    .pins_i(pins_i), .op_cmd_on_i(op_cmd_on_i), .fault_clear_i(fault_clear_i),
    .unit_cycles_i(unit_cycles_i), .out_en_o(out_en_o), .oc_status_o(oc_status_o),
    .alert_o(alert_o), .retrying_o(retrying_o), .cur_hold_o(cur_hold_o),
    .attempts_o(attempts_o));

`default_nettype wire

// *** tb/ocr_seq_tb.sv ***
// Self-checking bench for the fault retry sequencer
`timescale 1ns/1ps
`default_nettype none

`include "ocr_regs.svh"

module ocr_seq_tb;
    import ocr_pkg::*;
    logic clk, clk_link, rst_n, wr, op_on, fclr, stat_link, out_en, oc_stat, alert, rtry, hold;
    logic [7:0] wdata, rdata, b;
    logic [2:0] att, rf;
    logic [15:0] unit;
    ocr_pins_t pins;
    int bad_count, comparisons, cyc, last_rise, rises, gap_bad, exp_gap, d, c;
    bit prev_en;

    ocr_host_model ocr_host_model_inst (.clk_link_i(clk_link), .wr_o(wr), .wdata_o(wdata));
    ocr_seq ocr_seq_inst (.clk_i(clk), .rst_n_i(rst_n), .clk_link_i(clk_link),
        .rst_link_n_i(rst_n), .resp_wr_i(wr), .resp_wdata_i(wdata), .resp_rdata_o(rdata),
        .status_link_o(stat_link), .pins_i(pins), .op_cmd_on_i(op_on), .fault_clear_i(fclr),
        .unit_cycles_i(unit), .out_en_o(out_en), .oc_status_o(oc_stat), .alert_o(alert),
        .retrying_o(rtry), .cur_hold_o(hold), .attempts_o(att));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        clk_link = 1'b0;
        #3.3;
        forever #7.5 clk_link = ~clk_link;
    end

    // Restart attempts show as rising edges of the enable; spacing counted in core cycles
    always @(negedge clk) begin
        cyc++;
        if (out_en === 1'b1 && !prev_en) begin
            if (rises > 0 && cyc - last_rise != exp_gap) gap_bad++;
            rises++;
            last_rise = cyc;
        end
        prev_en = (out_en === 1'b1);
    end

    task automatic chk(input logic [15:0] act, input logic [15:0] exp);
        comparisons++;
        if (act !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %0h want %0h", $time, act, exp);
        end
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Realign to the core clock's falling edge after a link-side write
    task automatic wr_byte(input logic [7:0] v);
        ocr_host_model_inst.put(v);
        @(negedge clk);
    endtask

    task automatic recover;
        pins = '0;
        pins.pin_on = 1'b1;
        op_on = 1'b1;
        cyc_n(5);
        fclr = 1'b1;
        cyc_n(1);
        fclr = 1'b0;
        cyc_n(60);
        chk(out_en, 1'b1);
        chk(att, 3'h0);
        chk(oc_stat, 1'b0);
    endtask

    task automatic complete_run;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #150000;
        bad_count++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        pins = '0;
        pins.pin_on = 1'b1;
        op_on = 1'b1;
        fclr = 1'b0;
        unit = 16'h0002;
        b = 8'($urandom(32'h29f845b9));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        cyc_n(10);
        chk(rdata, `OCR_RESP_RST);
        chk(out_en, 1'b1);
        repeat (4) begin
            b = 8'($urandom);
            wr_byte(b);
            chk(rdata, b);
        end
        wr_byte({`OCR_MODE_RESUME, `OCR_RETRY_NONE, 3'h0});
        pins.oc_fault = 1'b1;
        cyc_n(8);
        chk(out_en, 1'b0);
        chk(alert, 1'b1);
        cyc_n(4);
        chk(stat_link, 1'b1);
        pins.oc_fault = 1'b0;
        cyc_n(8);
        chk(out_en, 1'b1);
        recover();
        // Ignore mode keeps running but still flags the fault
        wr_byte({`OCR_MODE_IGNORE, `OCR_RETRY_NONE, 3'h0});
        pins.oc_fault = 1'b1;
        cyc_n(8);
        chk(out_en, 1'b1);
        chk(oc_stat, 1'b1);
        recover();
        // Retry codes 0..6, then continuous retry stopped by command and by another fault
        for (int r = 0; r < 9; r++) begin
            d = $urandom_range(2, 0);
            // A one-cycle spacing could never show as a fresh rise of the enable
            unit = 16'($urandom_range(3, 2));
            exp_gap = unit * (1 << d);
            rf = (r > 6) ? `OCR_RETRY_CONT : r[2:0];
            wr_byte({`OCR_MODE_COND, rf, d[2:0]});
            rises = 0;
            gap_bad = 0;
            pins.oc_fault = 1'b1;
            pins.lv_fault = 1'b1;
            cyc_n(200);
            chk(gap_bad, 0);
            if (r > 6) begin
                chk(rises > 8, 1'b1);
                chk(rtry, 1'b1);
                if (r == 7) op_on = 1'b0;
                else pins.other_fault = 1'b1;
                cyc_n(10);
                rises = 0;
                cyc_n(100);
                chk(rises, 0);
                chk(rtry, 1'b0);
            end else begin
                chk(rises, r);
                chk(out_en, 1'b0);
                chk(att, r[2:0]);
                chk(rtry, 1'b0);
            end
            recover();
        end
        // Current-limit hold: still limiting at the end shuts down, otherwise keeps running
        unit = 16'h0002;
        for (c = 0; c < 2; c++) begin
            wr_byte({`OCR_MODE_DELAY, `OCR_RETRY_NONE, 3'h2});
            pins.oc_fault = 1'b1;
            pins.cur_limit = !c;
            cyc_n(5);
            chk(hold, 1'b1);
            chk(out_en, 1'b1);
            cyc_n(30);
            chk(out_en, c[0]);
            recover();
        end
        complete_run();
    end
endmodule // ocr_seq_tb

`default_nettype wire
